//--- pkg/dscw_pkg.sv
// constants and types for the drive state control word decoder
`default_nettype none
package dscw_pkg;
   // control word bit positions
   localparam int CW_SWITCH_ON_BIT = 0;
   localparam int CW_VOLTAGE_BIT = 1;
   localparam int CW_QSTOP_N_BIT = 2;
   localparam int CW_ENABLE_OP_BIT = 3;
   localparam int CW_FAULT_RST_BIT = 7;
   // status word low nibble per state, and flag positions
   localparam logic [3:0] SW_LOW_NOT_READY = 4'h0;
   localparam logic [3:0] SW_LOW_SW_ON_DIS = 4'h0;
   localparam logic [3:0] SW_LOW_READY = 4'h1;
   localparam logic [3:0] SW_LOW_SWITCHED_ON = 4'h3;
   localparam logic [3:0] SW_LOW_OP_ENABLED = 4'h7;
   localparam logic [3:0] SW_LOW_QSTOP = 4'h7;
   localparam logic [3:0] SW_LOW_FAULT_REACT = 4'hf;
   localparam logic [3:0] SW_LOW_FAULT = 4'h8;
   localparam int SW_QSTOP_N_BIT = 5;
   localparam int SW_SW_ON_DIS_BIT = 6;
   localparam logic [15:0] SW_RST = 16'h0000;
   // operating mode selector values
   localparam logic [7:0] MODE_NONE = 8'h00;
   localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
   localparam logic [7:0] MODE_VELOCITY = 8'h02;
   localparam logic [7:0] MODE_PROFILE_VEL = 8'h03;
   localparam logic [7:0] MODE_TORQUE_PROF = 8'h04;
   localparam logic [7:0] MODE_RESERVED_5 = 8'h05;
   localparam logic [7:0] MODE_HOMING = 8'h06;
   localparam logic [7:0] MODE_INTERP_POS = 8'h07;
   localparam logic [7:0] MODE_CSYNC_POS = 8'h08;
   localparam logic [7:0] MODE_CSYNC_VEL = 8'h09;
   localparam logic [7:0] MODE_CSYNC_TRQ = 8'h0a;
   // one bit per standard mode 0..10 that this drive runs
   localparam logic [10:0] MODE_SUPPORTED = 11'h74b;
   // dictionary objects and subindices
   localparam logic OBJ_LIMITS = 1'b0;
   localparam logic OBJ_STATUS = 1'b1;
   localparam logic [7:0] LIM_FIRST_SUB = 8'h01;
   localparam logic [7:0] LIM_RW_LAST_SUB = 8'h0d;
   localparam logic [7:0] LIM_PEAK_CUR_SUB = 8'h0e;
   localparam logic [7:0] LIM_TRQ_CEIL_SUB = 8'h0f;
   localparam int LIM_RW_COUNT = 13;
   localparam logic [31:0] LIM_RST = 32'h0000_0000;
   localparam logic [7:0] ST_FIRST_SUB = 8'h01;
   localparam logic [7:0] ST_LINK_SUB = 8'h09;
   localparam logic [7:0] ST_FAULT_GRP_SUB = 8'h0a;
   localparam logic [7:0] ST_WARN_GRP_SUB = 8'h0b;
   localparam logic [7:0] ST_GENERAL_SUB = 8'h0c;
   localparam int ST_BYTE_COUNT = 10;
   localparam logic [7:0] ST_BYTE_RST = 8'h00;
   // emergency message fields
   localparam logic [15:0] EMCY_CODE_NONE = 16'h0000;
   localparam logic [7:0] ERR_REG_NONE = 8'h00;
   localparam logic [7:0] ERR_REG_GENERIC = 8'h01;
   localparam logic [7:0] ERR_REG_RESERVED = 8'h40;
   localparam logic [15:0] EMCY_VENDOR_NONE = 16'h0000;

   typedef enum logic [2:0] {
      ST_NOT_READY, ST_SW_ON_DIS, ST_READY, ST_SWITCHED_ON,
      ST_OP_ENABLED, ST_QSTOP, ST_FAULT_REACT, ST_FAULT
   } dscw_state_e;

   typedef enum logic [2:0] {
      CMD_FAULT_RST, CMD_DIS_VOLT, CMD_QSTOP, CMD_SHUTDOWN, CMD_SWITCH_ON, CMD_ENABLE_OP
   } dscw_cmd_e;
endpackage : dscw_pkg
`default_nettype wire

//--- core/dscw_core.sv
// drive state machine, control/status word, mode decode, objects and emergencies
//
// Overview of operation
// - decode control word by fixed bit priority
// - full enable from ready passes through switched-on
// - not ready: low nibble 0000, bit6 low
// - switch-on disabled: nibble 0000, bit6 high
// - ready: nibble 0001, bit5 high, bit6 low
// - switched on: nibble 0011, bit5 high, bit6 low
// - operation enabled: nibble 0111, bit5 high
// - quickstop: nibble 0111, bits 5,6 low
// - fault reaction: nibble 1111, bit6 low
// - fault: nibble 1000, bit6 low
// - negative mode values are vendor modes
// - decode standard modes zero to ten
// - modes 8-10 cyclic sync; mode 5 and modes above 10 reserved
// - only a subset of modes supported
// - emit emergency code, error register, vendor code
// - subindex 9 link status byte, read only
// - subindex 10 packs drive bytes 1-4
// - subindex 11 packs drive byte 5 and the general board byte
// - subindex 7 memory and power byte
// - error register generic bit, bit6 reserved
`timescale 1ns/1ns
`default_nettype none
module dscw_core (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [15:0] control_word,
   input wire logic [7:0] mode_sel,
   input wire logic init_done,
   input wire logic fault_req,
   input wire logic reaction_done,
   input wire logic halt_done,
   input wire logic [15:0] fault_code,
   input wire logic [7:0] fault_err_bits,
   input wire logic [15:0] fault_vendor,
   input wire logic od_rd,
   input wire logic od_wr,
   input wire logic od_obj,
   input wire logic [7:0] od_sub,
   input wire logic [31:0] od_wdata,
   input wire logic [31:0] motor_peak_current,
   input wire logic [31:0] torque_ceiling,
   input wire logic [7:0] drive_state_byte_a,
   input wire logic [7:0] drive_state_byte_b,
   input wire logic [7:0] drive_state_byte_c,
   input wire logic [7:0] drive_state_byte_d,
   input wire logic [7:0] drive_state_byte_e,
   input wire logic [7:0] board_exception_byte,
   input wire logic [7:0] memory_power_byte,
   input wire logic [7:0] software_database_byte,
   input wire logic [7:0] link_interdrive_byte,
   input wire logic [7:0] general_board_byte,
   output logic [15:0] status_word,
   output logic [7:0] mode_active,
   output logic mode_vendor,
   output logic mode_reserved,
   output logic mode_supported,
   output logic drive_enable,
   output logic quickstop_active,
   output logic od_ack,
   output logic od_abort,
   output logic [31:0] od_rdata,
   output logic [31:0] following_error_limit,
   output logic [31:0] speed_clamp,
   output logic [31:0] torque_clamp,
   output logic emcy_valid,
   output logic [15:0] emcy_code,
   output logic [7:0] emcy_err_reg,
   output logic [15:0] emcy_vendor
);
   import dscw_pkg::*;

   typedef struct packed {
      dscw_state_e st;
      logic cw7_q;
      logic auto_op;
      logic [15:0] sw;
      logic [7:0] mode;
      logic m_vendor;
      logic m_reserved;
      logic m_supported;
      logic drv_en;
      logic qs_act;
      logic [LIM_RW_COUNT-1:0][31:0] lim;
      logic [ST_BYTE_COUNT-1:0][7:0] sbyte;
      logic ack;
      logic abort;
      logic [31:0] rdata;
      logic e_valid;
      logic [15:0] e_code;
      logic [7:0] e_reg;
      logic [15:0] e_vendor;
   } dscw_regs_s;

   dscw_regs_s r;
   dscw_regs_s next_r;
   dscw_cmd_e cmd;
   logic fault_rst_edge;
   logic [3:0] lim_idx;
   logic [3:0] st_idx;

   // command decode; fault reset outranks everything
   always_comb begin
      if (control_word[CW_FAULT_RST_BIT]) begin
         cmd = CMD_FAULT_RST;
      end else if (!control_word[CW_VOLTAGE_BIT]) begin
         cmd = CMD_DIS_VOLT;
      end else if (!control_word[CW_QSTOP_N_BIT]) begin
         cmd = CMD_QSTOP;
      end else if (!control_word[CW_SWITCH_ON_BIT]) begin
         cmd = CMD_SHUTDOWN;
      end else if (!control_word[CW_ENABLE_OP_BIT]) begin
         cmd = CMD_SWITCH_ON;
      end else begin
         cmd = CMD_ENABLE_OP;
      end
   end

   // a held bit 7 must not keep clearing new faults
   assign fault_rst_edge = control_word[CW_FAULT_RST_BIT] & ~r.cw7_q;
   assign lim_idx = 4'(od_sub - LIM_FIRST_SUB);
   assign st_idx = 4'(od_sub - ST_FIRST_SUB);

   always_comb begin
      next_r = r;
      next_r.cw7_q = control_word[CW_FAULT_RST_BIT];
      next_r.e_valid = 1'b0;
      next_r.ack = 1'b0;
      next_r.abort = 1'b0;
      next_r.auto_op = 1'b0;

      // state graph; commands with no edge from a state fall through unchanged
      if (fault_req && r.st != ST_FAULT_REACT && r.st != ST_FAULT) begin
         next_r.st = ST_FAULT_REACT;
         next_r.e_valid = 1'b1;
         next_r.e_code = fault_code;
         next_r.e_reg = (fault_err_bits | ERR_REG_GENERIC) & ~ERR_REG_RESERVED;
         next_r.e_vendor = fault_vendor;
      end else begin
         unique case (r.st)
            ST_NOT_READY: begin
               if (init_done) begin
                  next_r.st = ST_SW_ON_DIS;
               end
            end
            ST_SW_ON_DIS: begin
               if (cmd == CMD_SHUTDOWN) begin
                  next_r.st = ST_READY;
               end
            end
            ST_READY: begin
               // full enable lands in switched-on first, then goes on next cycle
               if (cmd == CMD_SWITCH_ON || cmd == CMD_ENABLE_OP) begin
                  next_r.st = ST_SWITCHED_ON;
                  next_r.auto_op = (cmd == CMD_ENABLE_OP);
               end else if (cmd == CMD_DIS_VOLT || cmd == CMD_QSTOP) begin
                  next_r.st = ST_SW_ON_DIS;
               end
            end
            ST_SWITCHED_ON: begin
               // auto step does not wait for the master to hold bit 3
               if (cmd == CMD_ENABLE_OP || r.auto_op) begin
                  next_r.st = ST_OP_ENABLED;
               end else if (cmd == CMD_SHUTDOWN) begin
                  next_r.st = ST_READY;
               end else if (cmd == CMD_DIS_VOLT || cmd == CMD_QSTOP) begin
                  next_r.st = ST_SW_ON_DIS;
               end
            end
            ST_OP_ENABLED: begin
               if (cmd == CMD_SWITCH_ON) begin
                  next_r.st = ST_SWITCHED_ON;
               end else if (cmd == CMD_SHUTDOWN) begin
                  next_r.st = ST_READY;
               end else if (cmd == CMD_DIS_VOLT) begin
                  next_r.st = ST_SW_ON_DIS;
               end else if (cmd == CMD_QSTOP) begin
                  next_r.st = ST_QSTOP;
               end
            end
            ST_QSTOP: begin
               if (cmd == CMD_ENABLE_OP) begin
                  next_r.st = ST_OP_ENABLED;
               end else if (cmd == CMD_DIS_VOLT || halt_done) begin
                  next_r.st = ST_SW_ON_DIS;
               end
            end
            ST_FAULT_REACT: begin
               if (reaction_done) begin
                  next_r.st = ST_FAULT;
               end
            end
            ST_FAULT: begin
               // reset refused while the fault source still stands
               if (fault_rst_edge && !fault_req) begin
                  next_r.st = ST_SW_ON_DIS;
                  next_r.e_valid = 1'b1;
                  next_r.e_code = EMCY_CODE_NONE;
                  next_r.e_reg = ERR_REG_NONE;
                  next_r.e_vendor = EMCY_VENDOR_NONE;
               end
            end
         endcase
      end

      // status word follows the next state so it changes with it
      next_r.sw = SW_RST;
      unique case (next_r.st)
         ST_NOT_READY: begin
            next_r.sw[3:0] = SW_LOW_NOT_READY;
         end
         ST_SW_ON_DIS: begin
            next_r.sw[3:0] = SW_LOW_SW_ON_DIS;
            next_r.sw[SW_SW_ON_DIS_BIT] = 1'b1;
         end
         ST_READY: begin
            next_r.sw[3:0] = SW_LOW_READY;
            next_r.sw[SW_QSTOP_N_BIT] = 1'b1;
         end
         ST_SWITCHED_ON: begin
            next_r.sw[3:0] = SW_LOW_SWITCHED_ON;
            next_r.sw[SW_QSTOP_N_BIT] = 1'b1;
         end
         ST_OP_ENABLED: begin
            next_r.sw[3:0] = SW_LOW_OP_ENABLED;
            next_r.sw[SW_QSTOP_N_BIT] = 1'b1;
         end
         ST_QSTOP: begin
            next_r.sw[3:0] = SW_LOW_QSTOP;
         end
         ST_FAULT_REACT: begin
            next_r.sw[3:0] = SW_LOW_FAULT_REACT;
         end
         ST_FAULT: begin
            next_r.sw[3:0] = SW_LOW_FAULT;
         end
      endcase
      next_r.drv_en = (next_r.st == ST_OP_ENABLED);
      next_r.qs_act = (next_r.st == ST_QSTOP);

      // mode selector is signed: the top bit marks vendor modes
      next_r.mode = mode_sel;
      next_r.m_vendor = mode_sel[7];
      next_r.m_reserved = !mode_sel[7] && (mode_sel == MODE_RESERVED_5 || mode_sel > MODE_CSYNC_TRQ);
      next_r.m_supported = !mode_sel[7] && mode_sel <= MODE_CSYNC_TRQ
         && MODE_SUPPORTED[mode_sel[3:0]];

      // status bytes are sampled every cycle so a read sees one snapshot
      next_r.sbyte[0] = drive_state_byte_a;
      next_r.sbyte[1] = drive_state_byte_b;
      next_r.sbyte[2] = drive_state_byte_c;
      next_r.sbyte[3] = drive_state_byte_d;
      next_r.sbyte[4] = drive_state_byte_e;
      next_r.sbyte[5] = board_exception_byte;
      next_r.sbyte[6] = memory_power_byte;
      next_r.sbyte[7] = software_database_byte;
      next_r.sbyte[8] = link_interdrive_byte;
      next_r.sbyte[9] = general_board_byte;

      // dictionary access; a write wins if both strobes come together
      if (od_wr) begin
         next_r.ack = 1'b1;
         next_r.rdata = 32'h0000_0000;
         if (od_obj == OBJ_LIMITS && od_sub >= LIM_FIRST_SUB && od_sub <= LIM_RW_LAST_SUB) begin
            next_r.lim[lim_idx] = od_wdata;
         end else begin
            next_r.abort = 1'b1;
         end
      end else if (od_rd) begin
         next_r.ack = 1'b1;
         next_r.rdata = 32'h0000_0000;
         if (od_obj == OBJ_LIMITS) begin
            if (od_sub >= LIM_FIRST_SUB && od_sub <= LIM_RW_LAST_SUB) begin
               next_r.rdata = r.lim[lim_idx];
            end else if (od_sub == LIM_PEAK_CUR_SUB) begin
               next_r.rdata = motor_peak_current;
            end else if (od_sub == LIM_TRQ_CEIL_SUB) begin
               next_r.rdata = torque_ceiling;
            end else begin
               next_r.abort = 1'b1;
            end
         end else begin
            if (od_sub >= ST_FIRST_SUB && od_sub <= ST_LINK_SUB) begin
               next_r.rdata = {24'h00_0000, r.sbyte[st_idx]};
            end else if (od_sub == ST_FAULT_GRP_SUB) begin
               next_r.rdata = {r.sbyte[3], r.sbyte[2], r.sbyte[1], r.sbyte[0]};
            end else if (od_sub == ST_WARN_GRP_SUB) begin
               next_r.rdata = {16'h0000, r.sbyte[9], r.sbyte[4]};
            end else if (od_sub == ST_GENERAL_SUB) begin
               next_r.rdata = {24'h00_0000, r.sbyte[9]};
            end else begin
               next_r.abort = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r.st <= ST_NOT_READY;
         r.cw7_q <= 1'b0;
         r.auto_op <= 1'b0;
         r.sw <= SW_RST;
         r.mode <= MODE_NONE;
         r.m_vendor <= 1'b0;
         r.m_reserved <= 1'b0;
         r.m_supported <= 1'b0;
         r.drv_en <= 1'b0;
         r.qs_act <= 1'b0;
         r.lim <= {LIM_RW_COUNT{LIM_RST}};
         r.sbyte <= {ST_BYTE_COUNT{ST_BYTE_RST}};
         r.ack <= 1'b0;
         r.abort <= 1'b0;
         r.rdata <= 32'h0000_0000;
         r.e_valid <= 1'b0;
         r.e_code <= EMCY_CODE_NONE;
         r.e_reg <= ERR_REG_NONE;
         r.e_vendor <= EMCY_VENDOR_NONE;
      end else begin
         r <= next_r;
      end
   end

   assign status_word = r.sw;
   assign mode_active = r.mode;
   assign mode_vendor = r.m_vendor;
   assign mode_reserved = r.m_reserved;
   assign mode_supported = r.m_supported;
   assign drive_enable = r.drv_en;
   assign quickstop_active = r.qs_act;
   assign od_ack = r.ack;
   assign od_abort = r.abort;
   assign od_rdata = r.rdata;
   assign following_error_limit = r.lim[0];
   assign speed_clamp = r.lim[6];
   assign torque_clamp = r.lim[12];
   assign emcy_valid = r.e_valid;
   assign emcy_code = r.e_code;
   assign emcy_err_reg = r.e_reg;
   assign emcy_vendor = r.e_vendor;
endmodule : dscw_core
`default_nettype wire

//--- verification/dscw_core_props.sv
// concurrent checks on the drive state decoder ports
`timescale 1ns/1ns
`default_nettype none
module dscw_core_props (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [15:0] control_word,
   input wire logic [7:0] mode_sel,
   input wire logic fault_req,
   input wire logic [15:0] fault_code,
   input wire logic od_rd,
   input wire logic od_wr,
   input wire logic od_obj,
   input wire logic [7:0] od_sub,
   input wire logic [15:0] status_word,
   input wire logic mode_vendor,
   input wire logic mode_reserved,
   input wire logic mode_supported,
   input wire logic drive_enable,
   input wire logic quickstop_active,
   input wire logic od_abort,
   input wire logic emcy_valid,
   input wire logic [15:0] emcy_code,
   input wire logic [7:0] emcy_err_reg
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_auto_enable; status_word == 16'h0021 && control_word[7] == 1'b0 && control_word[3:0] == 4'hf
      && !fault_req |=> status_word == 16'h0023 ##1 (status_word == 16'h0027 || status_word == 16'h000f); endproperty
   a_auto_enable: assert property (p_auto_enable) else $error("enable from ready did not pass switched-on");
   property p_sod_flag; status_word[6] |-> status_word[3:0] == 4'h0; endproperty
   a_sod_flag: assert property (p_sod_flag) else $error("bit 6 set outside switch-on disabled");
   property p_enabled; drive_enable |-> status_word[6:0] == 7'h27; endproperty
   a_enabled: assert property (p_enabled) else $error("operation enabled code wrong");
   property p_qstop; quickstop_active |-> status_word[6:5] == 2'b00 && status_word[3:0] == 4'h7; endproperty
   a_qstop: assert property (p_qstop) else $error("quickstop code wrong");
   property p_fault_entry; fault_req && status_word[3:0] != 4'hf && status_word[3:0] != 4'h8
      |=> status_word[3:0] == 4'hf && emcy_valid && emcy_code == $past(fault_code); endproperty
   a_fault_entry: assert property (p_fault_entry) else $error("fault entry or message missing");
   property p_err_reg; emcy_valid && emcy_code != 16'h0000 |-> emcy_err_reg[0] && !emcy_err_reg[6]; endproperty
   a_err_reg: assert property (p_err_reg) else $error("error register bits wrong");
   property p_fault_clear; status_word[3:0] == 4'h8 && $rose(control_word[7]) && !fault_req
      |=> status_word == 16'h0040 && emcy_valid; endproperty
   a_fault_clear: assert property (p_fault_clear) else $error("fault reset edge ignored");
   property p_vendor; mode_sel[7] |=> mode_vendor && !mode_supported; endproperty
   a_vendor: assert property (p_vendor) else $error("negative mode not vendor");
   property p_reserved; mode_sel == 8'h05 || (mode_sel >= 8'h0b && !mode_sel[7]) |=> mode_reserved; endproperty
   a_reserved: assert property (p_reserved) else $error("reserved mode not flagged");
   property p_ro_obj; od_wr && od_obj |=> od_abort; endproperty
   a_ro_obj: assert property (p_ro_obj) else $error("status object write accepted");
endmodule : dscw_core_props
bind dscw_core dscw_core_props u_props (.ref_clk(ref_clk), .rst(rst), .control_word(control_word),
   .mode_sel(mode_sel), .fault_req(fault_req), .fault_code(fault_code), .od_rd(od_rd), .od_wr(od_wr),
   .od_obj(od_obj), .od_sub(od_sub), .status_word(status_word), .mode_vendor(mode_vendor),
   .mode_reserved(mode_reserved), .mode_supported(mode_supported), .drive_enable(drive_enable),
   .quickstop_active(quickstop_active), .od_abort(od_abort), .emcy_valid(emcy_valid),
   .emcy_code(emcy_code), .emcy_err_reg(emcy_err_reg));
`default_nettype wire

//--- verification/dscw_master_model.sv
// fieldbus master model issuing control words
`timescale 1ns/1ns
`default_nettype none
module dscw_master_model (
   input wire logic ref_clk,
   output var logic [15:0] control_word
);
   initial control_word = 16'h0000;
   // called just after an edge; holds the word for the given edges
   task put(input logic [15:0] cw, input int hold);
      control_word = cw;
      repeat (hold) @(posedge ref_clk);
      #1;
   endtask : put
endmodule : dscw_master_model
`default_nettype wire

//--- verification/test_drive_state_control_word_decoder.sv
// self-checking bench for the drive state decoder
`timescale 1ns/1ns
`default_nettype none
module test_drive_state_control_word_decoder;
   import dscw_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] control_word;
   logic [7:0] mode_sel = 8'h00;
   logic init_done = 1'b0, fault_req = 1'b0, reaction_done = 1'b0, halt_done = 1'b0;
   logic [15:0] fault_code = 16'h0000, fault_vendor = 16'h0000;
   logic [7:0] fault_err_bits = 8'h00;
   logic od_rd = 1'b0, od_wr = 1'b0, od_obj = 1'b0;
   logic [7:0] od_sub = 8'h00;
   logic [31:0] od_wdata = 32'h0, peak = 32'h1357_9bdf, ceil = 32'h2468_ace0;
   logic [7:0] sb [10];
   logic [15:0] status_word, emcy_code, emcy_vendor;
   logic [7:0] mode_active, emcy_err_reg;
   logic mode_vendor, mode_reserved, mode_supported, drive_enable, quickstop_active;
   logic od_ack, od_abort, emcy_valid;
   logic [31:0] od_rdata, following_error_limit, speed_clamp, torque_clamp, lim [16];
   int failures = 0, checks = 0, cyc = 0;
   logic [15:0] cwv [12] = '{16'h0006, 16'h000f, 16'h000f, 16'h0007, 16'h0000, 16'h000f,
      16'h0006, 16'h0002, 16'h0006, 16'h000f, 16'h0007, 16'h000b};
   logic [15:0] swv [12] = '{16'h0021, 16'h0023, 16'h0027, 16'h0023, 16'h0040, 16'h0040,
      16'h0021, 16'h0040, 16'h0021, 16'h0023, 16'h0027, 16'h0007};
   logic [7:0] mv [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
      8'h0a, 8'h0b, 8'h7f, 8'h80, 8'hff};
   always #5 ref_clk = ~ref_clk;
   dscw_master_model master (.ref_clk(ref_clk), .control_word(control_word));
   dscw_core dut (.ref_clk(ref_clk), .rst(rst), .control_word(control_word), .mode_sel(mode_sel),
      .init_done(init_done), .fault_req(fault_req), .reaction_done(reaction_done), .halt_done(halt_done),
      .fault_code(fault_code), .fault_err_bits(fault_err_bits), .fault_vendor(fault_vendor), .od_rd(od_rd),
      .od_wr(od_wr), .od_obj(od_obj), .od_sub(od_sub), .od_wdata(od_wdata), .motor_peak_current(peak),
      .torque_ceiling(ceil), .drive_state_byte_a(sb[0]), .drive_state_byte_b(sb[1]),
      .drive_state_byte_c(sb[2]), .drive_state_byte_d(sb[3]), .drive_state_byte_e(sb[4]),
      .board_exception_byte(sb[5]), .memory_power_byte(sb[6]), .software_database_byte(sb[7]),
      .link_interdrive_byte(sb[8]), .general_board_byte(sb[9]), .status_word(status_word),
      .mode_active(mode_active), .mode_vendor(mode_vendor), .mode_reserved(mode_reserved),
      .mode_supported(mode_supported), .drive_enable(drive_enable), .quickstop_active(quickstop_active),
      .od_ack(od_ack), .od_abort(od_abort), .od_rdata(od_rdata), .following_error_limit(following_error_limit),
      .speed_clamp(speed_clamp), .torque_clamp(torque_clamp), .emcy_valid(emcy_valid), .emcy_code(emcy_code),
      .emcy_err_reg(emcy_err_reg), .emcy_vendor(emcy_vendor));
   task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task complete_run;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run
   // strobes stay up between calls so back-to-back requests never glitch
   task od_req(input logic wr, input logic obj, input logic [7:0] sub, input logic [31:0] wd,
      input logic [31:0] exp, input logic ab);
      od_wr = wr;
      od_rd = !wr;
      od_obj = obj;
      od_sub = sub;
      od_wdata = wd;
      @(posedge ref_clk);
      #1;
      check("od_ack", {31'h0, od_ack}, 32'h1);
      check("od_abort", {31'h0, od_abort}, {31'h0, ab});
      check("od_rdata", od_rdata, exp);
   endtask : od_req
   task od_idle;
      od_wr = 1'b0;
      od_rd = 1'b0;
   endtask : od_idle
   task sw_is(input logic [15:0] exp);
      check("status_word", {16'h0, status_word}, {16'h0, exp});
   endtask : sw_is
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         complete_run();
      end
   end
   initial begin
      foreach (sb[i]) sb[i] = 8'(i * 17 + 3);
      repeat (8) @(posedge ref_clk);
      #1;
      sw_is(16'h0000);
      rst = 1'b0;
      @(posedge ref_clk);
      #1;
      sw_is(16'h0000);
      init_done = 1'b1;
      @(posedge ref_clk);
      #1;
      sw_is(16'h0040);
      $display("test reset done");
      foreach (cwv[i]) begin
         master.put(cwv[i], 1);
         sw_is(swv[i]);
         check("drive_enable", {31'h0, drive_enable}, {31'h0, swv[i] == 16'h0027});
         check("quickstop_active", {31'h0, quickstop_active}, {31'h0, swv[i] == 16'h0007});
      end
      check("quickstop_active", {31'h0, quickstop_active}, 32'h1);
      halt_done = 1'b1;
      master.put(16'h000b, 1);
      sw_is(16'h0040);
      halt_done = 1'b0;
      $display("test states done");
      fault_req = 1'b1;
      fault_code = 16'h2340;
      fault_err_bits = 8'h42;
      fault_vendor = 16'h00f1;
      @(posedge ref_clk);
      #1;
      sw_is(16'h000f);
      check("emcy", {15'h0, emcy_valid, emcy_code}, {15'h0, 1'b1, 16'h2340});
      check("emcy_reg", {8'h0, emcy_err_reg, emcy_vendor}, {8'h0, 8'h03, 16'h00f1});
      reaction_done = 1'b1;
      master.put(16'h0080, 1);
      sw_is(16'h0008);
      check("emcy_valid", {31'h0, emcy_valid}, 32'h0);
      master.put(16'h0080, 1);
      sw_is(16'h0008);
      fault_req = 1'b0;
      master.put(16'h0080, 2);
      sw_is(16'h0008);
      master.put(16'h0000, 1);
      master.put(16'h0080, 1);
      sw_is(16'h0040);
      check("emcy", {15'h0, emcy_valid, emcy_code}, {15'h0, 1'b1, 16'h0000});
      check("emcy_reg", {8'h0, emcy_err_reg, emcy_vendor}, 32'h0);
      reaction_done = 1'b0;
      $display("test fault done");
      foreach (mv[i]) begin
         mode_sel = mv[i];
         @(posedge ref_clk);
         #1;
         check("mode_active", {24'h0, mode_active}, {24'h0, mv[i]});
         check("mode_vendor", {31'h0, mode_vendor}, {31'h0, mv[i][7]});
         check("mode_reserved", {31'h0, mode_reserved}, {31'h0, mv[i] == 8'h05 || (mv[i] >= 8'h0b && !mv[i][7])});
         check("mode_supported", {31'h0, mode_supported},
            {31'h0, !mv[i][7] && mv[i] <= 8'h0a && MODE_SUPPORTED[mv[i][3:0]]});
      end
      $display("test modes done");
      for (int s = 1; s <= 13; s++) begin
         lim[s] = 32'h0101_0101 * s + 32'h00a0_0000;
         od_req(1'b1, OBJ_LIMITS, 8'(s), lim[s], 32'h0, 1'b0);
      end
      lim[14] = peak;
      lim[15] = ceil;
      check("following_error_limit", following_error_limit, lim[1]);
      check("speed_clamp", speed_clamp, lim[7]);
      check("torque_clamp", torque_clamp, lim[13]);
      for (int s = 1; s <= 15; s++) od_req(1'b0, OBJ_LIMITS, 8'(s), 32'h0, lim[s], 1'b0);
      od_req(1'b1, OBJ_LIMITS, 8'h0e, 32'hdead_0001, 32'h0, 1'b1);
      od_req(1'b0, OBJ_LIMITS, 8'h00, 32'h0, 32'h0, 1'b1);
      od_req(1'b0, OBJ_LIMITS, 8'h10, 32'h0, 32'h0, 1'b1);
      od_req(1'b1, OBJ_STATUS, 8'h0a, 32'hdead_0002, 32'h0, 1'b1);
      od_req(1'b0, OBJ_LIMITS, 8'h0e, 32'h0, peak, 1'b0);
      for (int s = 1; s <= 9; s++) od_req(1'b0, OBJ_STATUS, 8'(s), 32'h0, {24'h0, sb[s - 1]}, 1'b0);
      od_req(1'b0, OBJ_STATUS, 8'h0a, 32'h0, {sb[3], sb[2], sb[1], sb[0]}, 1'b0);
      od_req(1'b0, OBJ_STATUS, 8'h0b, 32'h0, {16'h0, sb[9], sb[4]}, 1'b0);
      od_req(1'b0, OBJ_STATUS, 8'h0c, 32'h0, {24'h0, sb[9]}, 1'b0);
      od_req(1'b0, OBJ_STATUS, 8'h0d, 32'h0, 32'h0, 1'b1);
      od_idle();
      $display("test objects done");
      complete_run();
   end
endmodule : test_drive_state_control_word_decoder
`default_nettype wire
